// File: arw_ref_wake.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Reference stays on whenever the force-on bit is one.
// - Reference stays on while any output channel is powered and selection is 00.
// - Reference stays on while any output is in resistive power-down and selection is 00.
// - Forced-on reference still leaves a 188-cycle wait before the temperature result.
// - External-clock mode: internal reference turns off after a scan unless forced.
// - Off reference at analog request means waiting 218 serial clocks first.
// - Temperature request powers the reference and waits 244 serial clocks.
// - Temperature result is presented a further 188 serial clocks later.
// - External reference selections start analog conversions without waking the internal reference.
// - Default selection is internal converter reference, external output reference.
// - Differential select 00 or 01: no data byte, configuration unchanged.
// - Differential select 10: next byte goes into the unipolar-mode register.
// - Differential select 11: next byte goes into the bipolar-mode register.
// - With clock select 11, timing counts run on the serial clock.
module arw_ref_wake
   import arw_pkg::*;
(
   // ************************************************************
   // System clock side
   // ************************************************************
   input wire logic MCLK,
   input wire logic SYS_RST,
   // Force controls
   input wire logic REFERENCE_FORCE_ON,
   input wire logic [7:0] DAC_POWERED,
   input wire logic [7:0] DAC_PD_TO_REF,
   // Status
   output logic REF_ON,
   output logic BUSY,
   output logic [7:0] UNIPOLAR_CFG,
   output logic [7:0] BIPOLAR_CFG,
   output logic [1:0] REFERENCE_SELECT,
   output logic [1:0] CLOCK_SELECT,
   output logic [1:0] DIFFERENTIAL_SELECT,
   // ************************************************************
   // Serial link side
   // ************************************************************
   input wire logic SCLK,
   input wire logic CS_N,
   input wire logic DIN,
   // Conversion requests, on SCLK
   input wire logic AIN_REQ,
   input wire logic TEMP_REQ,
   input wire logic SCAN_DONE,
   // Conversion control, on SCLK
   output logic AIN_CONV_GO,
   output logic TEMP_RESULT_VALID
);
   // ************************************************************
   // Link state
   // ************************************************************
   typedef struct packed {
      arw_seq_t st;
      logic [CNT_W-1:0] cnt;
      logic ref_pwr;
      logic go;
      logic tvalid;
   } arw_link_t;

   arw_link_t l_r;
   arw_link_t l_nxt;
   logic [7:0] uni_s;
   logic [7:0] bip_s;
   logic [1:0] reference_select_s;
   logic [1:0] clock_select_s;
   logic [1:0] differential_select_s;
   logic force_raw;
   logic force_s;
   logic ref_pwr_m;
   logic busy_raw;

   // System-side copies, declared ahead of the force logic that reads them
   typedef struct packed {
      logic [7:0] uni;
      logic [7:0] bip;
      logic [1:0] reference_select;
      logic [1:0] clock_select;
      logic [1:0] differential_select;
   } arw_sys_t;

   arw_sys_t m_r;
   arw_sys_t m_nxt;
   logic [1:0] reference_select_m;
   logic busy_m;
   logic [7:0] uni_m;
   logic [7:0] bip_m;
   logic [1:0] clock_select_m;
   logic [1:0] differential_select_m;

   // Force condition uses the same selection copy that is shown on the port
   always_comb begin
      force_raw = REFERENCE_FORCE_ON;
      if (m_r.reference_select == REFERENCE_SELECT_INT_BOTH) begin
         force_raw = force_raw | (|DAC_POWERED) | (|DAC_PD_TO_REF);
      end
   end

   arw_setup_decode u_dec (
      .sclk(SCLK),
      .rst(SYS_RST),
      .cs_n(CS_N),
      .din(DIN),
      .uni_reg(uni_s),
      .bip_reg(bip_s),
      .ref_sel(reference_select_s),
      .clk_sel(clock_select_s),
      .diff_sel(differential_select_s)
   );

   // Force level crosses into the serial clock domain
   arw_sync u_force_sync (
      .clk(SCLK),
      .rst(SYS_RST),
      .d(force_raw),
      .q(force_s)
   );

   // Internal reference is needed by selections 00 and 10 only
   function automatic logic needs_int_ref(input logic [1:0] sel);
      needs_int_ref = (sel == REFERENCE_SELECT_INT_BOTH) || (sel == REFERENCE_SELECT_INT_ADC);
   endfunction : needs_int_ref

   // Wake and settle sequencer, timed by the serial clock
   always_comb begin
      l_nxt = l_r;
      l_nxt.go = 1'b0;
      l_nxt.tvalid = 1'b0;
      // Force is sampled into ref_pwr when a scan or measurement ends and held until a wake or temperature request sets it or the next one ends
      case (l_r.st)
         ARW_IDLE: begin
            if (clock_select_s == CLOCK_SELECT_EXT) begin
               if (TEMP_REQ) begin
                  // A forced-on reference skips the settle and goes straight to measurement
                  l_nxt.ref_pwr = 1'b1;
                  l_nxt.cnt = force_s ? TEMP_MEAS_CYC : TEMP_SETTLE_CYC;
                  l_nxt.st = force_s ? ARW_TEMP_MEAS : ARW_TEMP_SETTLE;
               end else if (AIN_REQ) begin
                  if (needs_int_ref(reference_select_s) && !l_r.ref_pwr && !force_s) begin
                     l_nxt.ref_pwr = 1'b1;
                     l_nxt.cnt = AIN_WAKE_CYC;
                     l_nxt.st = ARW_AIN_WAKE;
                  end else begin
                     // Already on, or external reference
                     l_nxt.go = 1'b1;
                     l_nxt.st = ARW_AIN_CONV;
                  end
               end
            end
         end
         ARW_AIN_WAKE: begin
            l_nxt.cnt = l_r.cnt - CNT_ONE;
            if (l_r.cnt == CNT_ONE) begin
               l_nxt.go = 1'b1;
               l_nxt.st = ARW_AIN_CONV;
            end
         end
         ARW_AIN_CONV: begin
            if (SCAN_DONE) begin
               l_nxt.ref_pwr = force_s;
               l_nxt.st = ARW_IDLE;
            end
         end
         ARW_TEMP_SETTLE: begin
            l_nxt.cnt = l_r.cnt - CNT_ONE;
            if (l_r.cnt == CNT_ONE) begin
               l_nxt.cnt = TEMP_MEAS_CYC;
               l_nxt.st = ARW_TEMP_MEAS;
            end
         end
         ARW_TEMP_MEAS: begin
            l_nxt.cnt = l_r.cnt - CNT_ONE;
            if (l_r.cnt == CNT_ONE) begin
               l_nxt.tvalid = 1'b1;
               l_nxt.ref_pwr = force_s;
               l_nxt.st = ARW_IDLE;
            end
         end
         default: l_nxt.st = ARW_IDLE;
      endcase
   end

   always_ff @(posedge SCLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         l_r <= '{st: ARW_IDLE, cnt: CNT_ZERO, ref_pwr: 1'b0, go: 1'b0, tvalid: 1'b0};
      end else begin
         l_r <= l_nxt;
      end
   end

   assign AIN_CONV_GO = l_r.go;
   assign TEMP_RESULT_VALID = l_r.tvalid;
   assign busy_raw = (l_r.st != ARW_IDLE);

   // ************************************************************
   // System clock side
   // ************************************************************
   // Config is quasi-static; each bit gets its own synchroniser
   genvar gi;
   for (gi = 0; gi < 8; gi++) begin : g_cfg
      arw_sync u_su (.clk(MCLK), .rst(SYS_RST), .d(uni_s[gi]), .q(uni_m[gi]));
      arw_sync u_sb (.clk(MCLK), .rst(SYS_RST), .d(bip_s[gi]), .q(bip_m[gi]));
   end
   for (gi = 0; gi < 2; gi++) begin : g_sel
      arw_sync u_sr (.clk(MCLK), .rst(SYS_RST), .d(reference_select_s[gi]), .q(reference_select_m[gi]));
      arw_sync u_sk (.clk(MCLK), .rst(SYS_RST), .d(clock_select_s[gi]), .q(clock_select_m[gi]));
      arw_sync u_sd (.clk(MCLK), .rst(SYS_RST), .d(differential_select_s[gi]), .q(differential_select_m[gi]));
   end
   arw_sync u_ref_sync (.clk(MCLK), .rst(SYS_RST), .d(l_r.ref_pwr), .q(ref_pwr_m));
   arw_sync u_busy_sync (.clk(MCLK), .rst(SYS_RST), .d(busy_raw), .q(busy_m));

   // Register status copies for clean data outputs
   always_comb begin
      m_nxt.uni = uni_m;
      m_nxt.bip = bip_m;
      m_nxt.reference_select = reference_select_m;
      m_nxt.clock_select = clock_select_m;
      m_nxt.differential_select = differential_select_m;
   end

   always_ff @(posedge MCLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         m_r <= '{uni: CHCFG_RESET, bip: CHCFG_RESET, reference_select: REFERENCE_SELECT_DEFAULT, clock_select: 2'b10, differential_select: 2'b00};
      end else begin
         m_r <= m_nxt;
      end
   end

   // Reference on when forced or while the sequencer holds it
   assign REF_ON = force_raw | ref_pwr_m;
   assign BUSY = busy_m;
   assign UNIPOLAR_CFG = m_r.uni;
   assign BIPOLAR_CFG = m_r.bip;
   assign REFERENCE_SELECT = m_r.reference_select;
   assign CLOCK_SELECT = m_r.clock_select;
   assign DIFFERENTIAL_SELECT = m_r.differential_select;
endmodule : arw_ref_wake

// File: arw_pkg.sv
package arw_pkg;

   // ************************************************************
   // Field codes
   // ************************************************************
   localparam logic [1:0] REFERENCE_SELECT_INT_BOTH = 2'b00;
   localparam logic [1:0] REFERENCE_SELECT_EXT_SE = 2'b01;
   localparam logic [1:0] REFERENCE_SELECT_INT_ADC = 2'b10;
   localparam logic [1:0] REFERENCE_SELECT_EXT_DIFF = 2'b11;
   localparam logic [1:0] REFERENCE_SELECT_DEFAULT = REFERENCE_SELECT_INT_ADC;
   localparam logic [1:0] CLOCK_SELECT_EXT = 2'b11;
   localparam logic [1:0] DIFFERENTIAL_SELECT_UNI = 2'b10;
   localparam logic [1:0] DIFFERENTIAL_SELECT_BIP = 2'b11;
   localparam int DIFFERENTIAL_SELECT_DATA_BIT = 1;
   localparam int DIFFERENTIAL_SELECT_BIP_BIT = 0;
   localparam logic [7:0] CHCFG_RESET = 8'h00;

   // ************************************************************
   // Delay counts, in serial clock cycles
   // ************************************************************
   localparam int CNT_W = 9;
   localparam logic [CNT_W-1:0] AIN_WAKE_CYC = 9'd218;
   localparam logic [CNT_W-1:0] TEMP_SETTLE_CYC = 9'd244;
   localparam logic [CNT_W-1:0] TEMP_MEAS_CYC = 9'd188;
   localparam logic [CNT_W-1:0] CNT_ONE = 9'd1;
   localparam logic [CNT_W-1:0] CNT_ZERO = 9'd0;
   localparam int CMD_BITS = 8;
   localparam logic [3:0] BITCNT_ZERO = 4'h0;
   localparam logic [3:0] BITCNT_LAST = 4'h7;

   // Sequencer states
   typedef enum logic [2:0] {
      ARW_IDLE,
      ARW_AIN_WAKE,
      ARW_AIN_CONV,
      ARW_TEMP_SETTLE,
      ARW_TEMP_MEAS
   } arw_seq_t;

   // Setup decode states
   typedef enum logic [1:0] {
      ARW_CMD,
      ARW_DATA,
      ARW_IGNORE
   } arw_dec_t;

endpackage : arw_pkg

// File: arw_sync.sv
`timescale 1ns/1ps
// Two-flop level synchroniser
module arw_sync (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Level
   input wire logic d,
   output logic q
);
   typedef struct packed {
      logic s1;
      logic s2;
   } arw_sync_t;

   arw_sync_t st_r;
   arw_sync_t st_nxt;

   // Only the second stage is read
   always_comb begin
      st_nxt.s1 = d;
      st_nxt.s2 = st_r.s1;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign q = st_r.s2;
endmodule : arw_sync

// File: arw_setup_decode.sv
`timescale 1ns/1ps
// Setup command decode on the serial clock
module arw_setup_decode
   import arw_pkg::*;
(
   // Serial clock domain
   input wire logic sclk,
   input wire logic rst,
   input wire logic cs_n,
   input wire logic din,
   // Channel configuration
   output logic [7:0] uni_reg,
   output logic [7:0] bip_reg,
   output logic [1:0] ref_sel,
   output logic [1:0] clk_sel,
   output logic [1:0] diff_sel
);
   typedef struct packed {
      arw_dec_t st;
      logic [3:0] bitcnt;
      logic [7:0] shreg;
      logic dest_bip;
      logic [7:0] uni;
      logic [7:0] bip;
      logic [1:0] reference_select;
      logic [1:0] clock_select;
      logic [1:0] differential_select;
   } arw_dec_state_t;

   arw_dec_state_t s_r;
   arw_dec_state_t s_nxt;
   logic [7:0] byte_in;

   // Shift MSB first; a byte completes on the eighth bit
   always_comb begin
      s_nxt = s_r;
      byte_in = {s_r.shreg[6:0], din};
      if (cs_n) begin
         s_nxt.st = ARW_CMD;
         s_nxt.bitcnt = BITCNT_ZERO;
      end else begin
         s_nxt.shreg = byte_in;
         s_nxt.bitcnt = (s_r.bitcnt == BITCNT_LAST) ? BITCNT_ZERO : s_r.bitcnt + 4'h1;
         if (s_r.bitcnt == BITCNT_LAST) begin
            case (s_r.st)
               ARW_CMD: begin
                  // Only setup bytes (01xxxxxx) are decoded here
                  if (byte_in[7:6] == 2'b01) begin
                     s_nxt.clock_select = byte_in[5:4];
                     s_nxt.reference_select = byte_in[3:2];
                     s_nxt.differential_select = byte_in[1:0];
                     if (byte_in[DIFFERENTIAL_SELECT_DATA_BIT]) begin
                        s_nxt.st = ARW_DATA;
                        s_nxt.dest_bip = byte_in[DIFFERENTIAL_SELECT_BIP_BIT];
                     end // else no data byte follows
                  end
               end
               ARW_DATA: begin
                  if (s_r.dest_bip) begin
                     s_nxt.bip = byte_in;
                  end else begin
                     s_nxt.uni = byte_in;
                  end
                  // Host closes the frame after 16 clocks
                  s_nxt.st = ARW_CMD;
               end
               default: s_nxt.st = ARW_CMD;
            endcase
         end
      end
   end

   // Clock select resets to external-clock high bit set
   always_ff @(posedge sclk or posedge rst) begin
      if (rst) begin
         s_r <= '{st: ARW_CMD, bitcnt: BITCNT_ZERO, shreg: CHCFG_RESET, dest_bip: 1'b0,
                  uni: CHCFG_RESET, bip: CHCFG_RESET, reference_select: REFERENCE_SELECT_DEFAULT,
                  clock_select: 2'b10, differential_select: 2'b00};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign uni_reg = s_r.uni;
   assign bip_reg = s_r.bip;
   assign ref_sel = s_r.reference_select;
   assign clk_sel = s_r.clock_select;
   assign diff_sel = s_r.differential_select;
endmodule : arw_setup_decode

// File: arw_chk.sv
`timescale 1ns/1ps
module arw_chk
   import arw_pkg::*;
(
   // Clocks and reset
   input wire logic MCLK,
   input wire logic SYS_RST,
   input wire logic SCLK,
   // Force and status
   input wire logic REFERENCE_FORCE_ON,
   input wire logic [7:0] DAC_POWERED,
   input wire logic [7:0] DAC_PD_TO_REF,
   input wire logic REF_ON,
   input wire logic [7:0] UNIPOLAR_CFG,
   input wire logic [7:0] BIPOLAR_CFG,
   input wire logic [1:0] REFERENCE_SELECT,
   input wire logic [1:0] CLOCK_SELECT,
   input wire logic [1:0] DIFFERENTIAL_SELECT,
   // Link side
   input wire logic AIN_REQ,
   input wire logic TEMP_REQ,
   input wire logic SCAN_DONE,
   input wire logic AIN_CONV_GO,
   input wire logic TEMP_RESULT_VALID
);
   logic ext_mode;
   logic no_force;
   // Qualifiers: ext_mode is shared by several properties, no_force is used by AST_AUTO_OFF alone
   assign ext_mode = (CLOCK_SELECT == CLOCK_SELECT_EXT);
   assign no_force = !REFERENCE_FORCE_ON && !(|DAC_POWERED) && !(|DAC_PD_TO_REF);
   // ****************************************
   // Wait sequences; s_wake allows one edge of slack each way, the temperature ones two edges early and none late
   // ****************************************
   sequence s_wake;
      ##[218:220] AIN_CONV_GO;
   endsequence
   sequence s_temp_full;
      ##[431:433] TEMP_RESULT_VALID;
   endsequence
   sequence s_temp_forced;
      ##[187:189] TEMP_RESULT_VALID;
   endsequence
   AST_FORCE_ON: assert property (@(posedge MCLK) disable iff (SYS_RST)
      REFERENCE_FORCE_ON |-> REF_ON) else $error("force bit left reference off");
   AST_DAC_ON: assert property (@(posedge MCLK) disable iff (SYS_RST)
      (|DAC_POWERED) && REFERENCE_SELECT == REFERENCE_SELECT_INT_BOTH |-> REF_ON) else $error("powered output left ref off");
   AST_PD_ON: assert property (@(posedge MCLK) disable iff (SYS_RST)
      (|DAC_PD_TO_REF) && REFERENCE_SELECT == REFERENCE_SELECT_INT_BOTH |-> REF_ON) else $error("pulldown left ref off");
   AST_AUTO_OFF: assert property (@(posedge MCLK) disable iff (SYS_RST)
      SCAN_DONE && no_force |-> ##[1:16] !REF_ON) else $error("reference stayed on after scan");
   AST_AIN_WAKE: assert property (@(posedge SCLK) disable iff (SYS_RST)
      AIN_REQ && ext_mode && !REFERENCE_SELECT[0] && !REF_ON |-> s_wake) else $error("wake delay wrong");
   AST_AIN_DIRECT: assert property (@(posedge SCLK) disable iff (SYS_RST)
      AIN_REQ && ext_mode && REFERENCE_SELECT[0] |-> ##1 AIN_CONV_GO) else $error("external ref delayed");
   AST_TEMP_WAIT: assert property (@(posedge SCLK) disable iff (SYS_RST)
      TEMP_REQ && ext_mode && !REF_ON |-> s_temp_full) else $error("temperature timing wrong");
   AST_TEMP_FORCED: assert property (@(posedge SCLK) disable iff (SYS_RST)
      TEMP_REQ && ext_mode && REFERENCE_FORCE_ON |-> s_temp_forced) else $error("forced temp timing wrong");
   AST_NOT_EXT: assert property (@(posedge SCLK) disable iff (SYS_RST)
      (AIN_REQ || TEMP_REQ) && !ext_mode |-> ##1 !AIN_CONV_GO && !TEMP_RESULT_VALID) else $error("request taken");
   AST_UNI_WRITE: assert property (@(posedge SCLK) disable iff (SYS_RST)
      $changed(UNIPOLAR_CFG) |-> DIFFERENTIAL_SELECT == DIFFERENTIAL_SELECT_UNI) else $error("stray unipolar write");
   AST_BIP_WRITE: assert property (@(posedge SCLK) disable iff (SYS_RST)
      $changed(BIPOLAR_CFG) |-> DIFFERENTIAL_SELECT == DIFFERENTIAL_SELECT_BIP) else $error("stray bipolar write");
endmodule : arw_chk
bind arw_ref_wake arw_chk u_chk (.MCLK(MCLK), .SYS_RST(SYS_RST), .SCLK(SCLK),
   .REFERENCE_FORCE_ON(REFERENCE_FORCE_ON), .DAC_POWERED(DAC_POWERED), .DAC_PD_TO_REF(DAC_PD_TO_REF),
   .REF_ON(REF_ON), .UNIPOLAR_CFG(UNIPOLAR_CFG), .BIPOLAR_CFG(BIPOLAR_CFG),
   .REFERENCE_SELECT(REFERENCE_SELECT), .CLOCK_SELECT(CLOCK_SELECT),
   .DIFFERENTIAL_SELECT(DIFFERENTIAL_SELECT), .AIN_REQ(AIN_REQ), .TEMP_REQ(TEMP_REQ),
   .SCAN_DONE(SCAN_DONE), .AIN_CONV_GO(AIN_CONV_GO), .TEMP_RESULT_VALID(TEMP_RESULT_VALID));

// File: arw_host.sv
`timescale 1ns/1ps
module arw_host (
   // Serial link
   output logic sclk,
   output logic cs_n,
   output logic din,
   // Conversion requests
   output logic ain_req,
   output logic temp_req,
   output logic scan_done
);
   // ****************************************
   // Link clock
   // ****************************************
   // Runs free: in this mode it also times the conversions
   initial begin
      sclk = 1'b0;
      #7;
      forever #24 sclk = ~sclk;
   end
   // Idle levels
   initial begin
      cs_n = 1'b1;
      din = 1'b0;
      ain_req = 1'b0;
      temp_req = 1'b0;
      scan_done = 1'b0;
   end
   // Frame of n bits, MSB first; 16 when a data byte rides along
   task automatic shift(input logic [15:0] d, input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge sclk);
         cs_n <= 1'b0;
         din <= d[15-i];
      end
      @(posedge sclk);
      cs_n <= 1'b1;
      din <= ~d[16-n]; // Released line shows no stale bit
   endtask : shift
   // One-cycle pulse: 0 analog, 1 temperature, 2 scan done
   task automatic req(input logic [1:0] k);
      @(posedge sclk);
      ain_req <= (k == 2'd0);
      temp_req <= (k == 2'd1);
      scan_done <= (k == 2'd2);
      @(posedge sclk);
      ain_req <= 1'b0;
      temp_req <= 1'b0;
      scan_done <= 1'b0;
   endtask : req
endmodule : arw_host

// File: tb.sv
`timescale 1ns/1ps
module tb;
   import arw_pkg::*;
   logic MCLK, SYS_RST, force_on, ref_on, busy, go, tvalid;
   logic sclk, cs_n, din, ain_req, temp_req, scan_done;
   logic [7:0] dac_pwr, dac_pd, uni, bip;
   logic [1:0] rsel, csel, dsel;
   logic [15:0] n;
   int err_count, num_checks;
   arw_host host (.sclk(sclk), .cs_n(cs_n), .din(din), .ain_req(ain_req), .temp_req(temp_req),
      .scan_done(scan_done));
   arw_ref_wake DUT (.MCLK(MCLK), .SYS_RST(SYS_RST), .REFERENCE_FORCE_ON(force_on),
      .DAC_POWERED(dac_pwr), .DAC_PD_TO_REF(dac_pd), .REF_ON(ref_on), .BUSY(busy),
      .UNIPOLAR_CFG(uni), .BIPOLAR_CFG(bip), .REFERENCE_SELECT(rsel), .CLOCK_SELECT(csel),
      .DIFFERENTIAL_SELECT(dsel), .SCLK(sclk), .CS_N(cs_n), .DIN(din), .AIN_REQ(ain_req),
      .TEMP_REQ(temp_req), .SCAN_DONE(scan_done), .AIN_CONV_GO(go), .TEMP_RESULT_VALID(tvalid));
   // System clock
   initial begin
      MCLK = 1'b0;
      forever #10 MCLK = ~MCLK;
   end
   // ****************************************
   // Helpers
   // ****************************************
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : check
   // Link edges from the taking edge to the answer; 0 is a pulse at that edge, 600 means none came
   task automatic time_to(input logic temp);
      n = 16'd0;
      #1;
      while (((temp ? tvalid : go) !== 1'b1) && n < 16'd600) begin
         @(posedge sclk);
         #1;
         n++;
      end
   endtask : time_to
   task automatic setup(input logic [1:0] cs, input logic [1:0] rs, input logic [1:0] ds, input logic [7:0] d);
      if (ds[1]) host.shift({2'b01, cs, rs, ds, d}, 16);
      else host.shift({2'b01, cs, rs, ds, 8'h00}, 8);
      repeat (3) @(posedge sclk);
   endtask : setup
   task automatic mset(input logic f, input logic [7:0] p, input logic [7:0] q);
      @(posedge MCLK);
      force_on <= f;
      dac_pwr <= p;
      dac_pd <= q;
      repeat (20) @(posedge MCLK);
   endtask : mset
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_defaults;
      check(rsel, REFERENCE_SELECT_DEFAULT, "ref select");
      check({csel, dsel, uni, bip, ref_on, busy}, {4'b1000, CHCFG_RESET, CHCFG_RESET, 2'b00}, "reset");
   endtask : t_defaults
   // Unipolar then bipolar write, then data-less codes followed by a foreign byte
   task automatic t_config;
      setup(CLOCK_SELECT_EXT, REFERENCE_SELECT_INT_ADC, DIFFERENTIAL_SELECT_UNI, 8'ha5);
      check({uni, bip}, {8'ha5, CHCFG_RESET}, "unipolar");
      setup(CLOCK_SELECT_EXT, REFERENCE_SELECT_INT_ADC, DIFFERENTIAL_SELECT_BIP, 8'h3c);
      check({uni, bip}, 16'ha53c, "bipolar");
      for (int d = 0; d < 2; d++) begin
         setup(CLOCK_SELECT_EXT, REFERENCE_SELECT_INT_ADC, 2'(d), 8'h00);
         host.shift(16'hc300, 8);
         check({uni, bip, 6'h00, dsel}, {16'ha53c, 8'(d)}, "no data");
      end
   endtask : t_config
   task automatic t_force;
      mset(1'b1, 8'h00, 8'h00);
      check(ref_on, 1'b1, "force bit");
      setup(CLOCK_SELECT_EXT, REFERENCE_SELECT_INT_BOTH, 2'b00, 8'h00);
      mset(1'b0, 8'h10, 8'h00);
      check(ref_on, 1'b1, "output powered");
      mset(1'b0, 8'h00, 8'h01);
      check(ref_on, 1'b1, "output pulled down");
      mset(1'b0, 8'h00, 8'h00);
      check(ref_on, 1'b0, "released");
   endtask : t_force
   task automatic t_ain;
      setup(CLOCK_SELECT_EXT, REFERENCE_SELECT_INT_ADC, 2'b00, 8'h00);
      host.req(2'd0);
      time_to(1'b0);
      check(n, 16'(AIN_WAKE_CYC), "wake delay");
      check(busy, 1'b1, "busy converting");
      host.req(2'd2);
      repeat (20) @(posedge MCLK);
      check(ref_on, 1'b0, "auto off");
      mset(1'b1, 8'h00, 8'h00);
      host.req(2'd0);
      time_to(1'b0);
      check(n, 16'd0, "ref already on");
      host.req(2'd2);
      mset(1'b0, 8'h00, 8'h00);
      for (int r = 1; r < 4; r += 2) begin
         setup(CLOCK_SELECT_EXT, 2'(r), 2'b00, 8'h00);
         host.req(2'd0);
         time_to(1'b0);
         check(n, 16'd0, "external ref");
         host.req(2'd2);
         repeat (20) @(posedge MCLK);
      end
      setup(2'b10, REFERENCE_SELECT_INT_ADC, 2'b00, 8'h00);
      host.req(2'd0);
      time_to(1'b0);
      check(n, 16'd600, "other clock mode");
      check(busy, 1'b0, "request refused");
   endtask : t_ain
   task automatic t_temp;
      for (int r = 0; r < 4; r++) begin
         setup(CLOCK_SELECT_EXT, 2'(r), 2'b00, 8'h00);
         host.req(2'd1);
         time_to(1'b1);
         check(n, 16'(TEMP_SETTLE_CYC) + 16'(TEMP_MEAS_CYC), "temp settle");
         repeat (20) @(posedge MCLK);
      end
      mset(1'b1, 8'h00, 8'h00);
      host.req(2'd1);
      time_to(1'b1);
      check(n, 16'(TEMP_MEAS_CYC), "forced temp");
   endtask : t_temp
   task automatic results;
      $display("Checks %0d, errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : results
   // Watchdog, well beyond the expected run of about 150 us
   initial begin
      #1000000;
      err_count++;
      results();
   end
   // Main sequence
   initial begin
      SYS_RST = 1'b1;
      force_on = 1'b0;
      dac_pwr = 8'h00;
      dac_pd = 8'h00;
      err_count = 0;
      num_checks = 0;
      repeat (5) @(posedge MCLK);
      SYS_RST <= 1'b0;
      repeat (3) @(posedge sclk);
      t_defaults();
      t_config();
      t_force();
      t_ain();
      t_temp();
      results();
   end
endmodule : tb
